// ===== include/ast_defs.vh
// What this block does
// R1: Receive-pin select picks primary or alternate pin.
// R2: Software changes modes only while stopped.
// R3: Length code selects eight down to five bits.
// R4: Parity code selects even, odd or none.
// R5: Mode bits select stops, inversion, bit order.
// R6: Baud count register resets to 0ffh.
// R7: Bit period is count plus one ticks.
// R8: Counts below eight behave as eight.
// R9: Any status write clears every flag.
// R10: Framing flag reflects bad start or stop.
// R11: Overrun flag when unread byte is replaced.
// R12: Parity flag when received parity mismatches.
// R13: Buffer-full tracks pending transmit byte.
// R14: Frame is start, data, parity, stops.
// R15: Short received data right-aligned, upper zero.
// R16: Transmit pin held high in receive mode.
// R17: Enable in transmit mode starts bit clock.
// R18: Interrupt at start bit; refill continues stream.
// R19: No refill ends frame, clears enable, interrupts.
// R20: Receiver hunts start bit, samples mid-bit.
// R21: Buffer loads on fall, checks on rise.
// R22: Reception repeats until software clears enable.
// R23: Clock select picks low, doubled or high.
// R24: Mode bit zero selects transmit or receive.
// R25: Enable bit starts and stops communication.
// R26: Negative logic inverts every line bit.
`ifndef AST_DEFS_VH
`define AST_DEFS_VH

// ============================================================
// Register indices; byte address is four times the index.
`define AST_IDX_BUF    16'hf290
`define AST_IDX_CTL    16'hf291
`define AST_IDX_MODE0  16'hf292
`define AST_IDX_MODE1  16'hf293
`define AST_IDX_BAUD   16'hf294
`define AST_IDX_STAT   16'hf296

// ============================================================
// Field positions.
`define AST_CTL_EN     0
`define AST_M0_RX      0
`define AST_M0_CK_LO   1
`define AST_M0_CK_HI   2
`define AST_M0_RSEL    4
`define AST_M1_LG_LO   0
`define AST_M1_LG_HI   1
`define AST_M1_PT_LO   2
`define AST_M1_PT_HI   3
`define AST_M1_STP     4
`define AST_M1_NEG     5
`define AST_M1_DIR     6
`define AST_ST_FER     0
`define AST_ST_OER     1
`define AST_ST_PER     2
`define AST_ST_FUL     3

// ============================================================
// Reset values and counts.
`define AST_RST_BYTE   8'h00
`define AST_RST_BAUD   16'h00ff
`define AST_BAUD_MIN   16'h0008
`define AST_DATA_MAX   4'h8
`define AST_FRAME_W    12
`define AST_ONE4       4'h1

`endif

// ===== logic/ast_sync2.v
`timescale 1ns/1ps
`default_nettype none
module ast_sync2 (
	// Clock and reset.
	input  wire i_clk_sys,
	input  wire i_reset_n,
	// Asynchronous level in, synchronised level out.
	input  wire i_async,
	output reg  o_sync
);

	reg meta_reg;

	// ============================================================
	// Two flops; the first is read by the second only.
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_reg <= 1'b1;
			o_sync   <= 1'b1;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule // ast_sync2
`default_nettype wire

// ===== logic/ast_baud_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
module ast_baud_gen (
	// Clock and reset.
	input  wire        i_clk_sys,
	input  wire        i_reset_n,
	// Control.
	input  wire        i_tick,
	input  wire        i_run,
	input  wire        i_restart,
	input  wire [15:0] i_count,
	// Transfer clock edges as pulses.
	output reg         o_fall,
	output reg         o_rise
);

	wire [15:0] period;
	wire [15:0] half;
	reg  [15:0] cnt_reg;

	// Small counts are clamped so the receiver keeps a usable midpoint.
	assign period = (i_count < `AST_BAUD_MIN) ? `AST_BAUD_MIN : i_count; // R8
	assign half   = {1'b0, period[15:1]};

	// ============================================================
	// One bit period is period plus one source ticks.
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cnt_reg <= 16'h0000;
			o_fall  <= 1'b0;
			o_rise  <= 1'b0;
		end
		else if (!i_run)
		begin
			cnt_reg <= 16'h0000;
			o_fall  <= 1'b0;
			o_rise  <= 1'b0;
		end
		else if (i_restart)
		begin
			cnt_reg <= 16'h0000; // R17 R20
			o_fall  <= 1'b1;
			o_rise  <= 1'b0;
		end
		else
		begin
			o_fall <= i_tick & (cnt_reg == period); // R7
			o_rise <= i_tick & (cnt_reg == half);   // R20
			if (i_tick)
			begin
				if (cnt_reg == period)
					cnt_reg <= 16'h0000;
				else
					cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

endmodule // ast_baud_gen
`default_nettype wire

// ===== logic/ast_uart.v
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
module ast_uart (
	// Clock and reset.
	input  wire        i_clk_sys,
	input  wire        i_reset_n,
	// APB slave.
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [17:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// Baud source clocks, sampled as levels.
	input  wire        i_low_speed_clock,
	input  wire        i_low_speed_clock_x2,
	input  wire        i_high_speed_clock,
	// Serial pins.
	input  wire        i_primary_rx_candidate_pin,
	input  wire        i_alternate_rx_candidate_pin,
	output reg         o_serial_out_pin,
	// Interrupt request pulse.
	output reg         o_uart_irq
);

	localparam [3:0] RX_HUNT = 4'b0001;
	localparam [3:0] RX_BITS = 4'b0010;
	localparam [3:0] RX_LOAD = 4'b0100;
	localparam [3:0] RX_STOP = 4'b1000;

	// ============================================================
	// Software-visible state, then the unread marker and edge-detect delays.
	reg         comm_enable_reg;
	reg  [7:0]  channel_mode_config_reg;
	reg  [7:0]  frame_format_config_reg;
	reg  [15:0] baud_divider_count_reg;
	reg  [7:0]  shared_data_buffer_reg;
	reg         framing_error_flag_reg;
	reg         overrun_error_flag_reg;
	reg         parity_error_flag_reg;
	reg         buffer_full_flag_reg;
	reg         unread_reg;
	reg         en_d_reg;
	reg         src_d_reg;

	// Transmit and receive engine state and combinational strobes.
	reg  [`AST_FRAME_W-1:0] tx_sh_reg;
	reg  [3:0]  tx_left_reg;
	reg         tx_line_reg;
	reg         tx_load;
	reg         tx_done;
	reg  [3:0]  rx_state_reg;
	reg  [3:0]  rx_cnt_reg;
	reg  [7:0]  rx_sh_reg;
	reg         rx_start_bad_reg;
	reg         rx_par_reg;
	reg         rx_load;
	reg         rx_done;
	reg         rx_stop_bad;

	// Combinational helpers.
	reg  [`AST_FRAME_W-1:0] tx_frame;
	reg         tx_par;
	reg  [31:0] rdata_next;
	integer     i;

	// ============================================================
	// Field decode.
	wire        rx_mode    = channel_mode_config_reg[`AST_M0_RX];   // R24
	wire        ck_hi      = channel_mode_config_reg[`AST_M0_CK_HI];
	wire        ck_lo      = channel_mode_config_reg[`AST_M0_CK_LO];
	wire        pin_sel    = channel_mode_config_reg[`AST_M0_RSEL];
	wire [1:0]  len_code   = frame_format_config_reg[`AST_M1_LG_HI:`AST_M1_LG_LO];
	wire [3:0]  data_len   = `AST_DATA_MAX - {2'b00, len_code};     // R3
	wire        par_en     = ~frame_format_config_reg[`AST_M1_PT_HI]; // R4
	wire        par_odd    = frame_format_config_reg[`AST_M1_PT_LO];  // R4
	wire        two_stop   = frame_format_config_reg[`AST_M1_STP];  // R5
	wire        neg        = frame_format_config_reg[`AST_M1_NEG];  // R5
	wire        msb_first  = frame_format_config_reg[`AST_M1_DIR];  // R5
	wire [3:0]  par_cnt    = {3'b000, par_en};
	wire [3:0]  tx_bits    = `AST_ONE4 + data_len + par_cnt + `AST_ONE4
		+ {3'b000, two_stop};                                     // R14

	// ============================================================
	// APB decode; the slave never waits.
	wire [15:0] idx      = i_paddr[17:2];
	wire        acc      = i_psel & i_penable;
	wire        wr       = acc & i_pwrite;
	wire        rd       = acc & ~i_pwrite;
	wire        hit_buf  = (idx == `AST_IDX_BUF);
	wire        hit_ctl  = (idx == `AST_IDX_CTL);
	wire        hit_m0   = (idx == `AST_IDX_MODE0);
	wire        hit_m1   = (idx == `AST_IDX_MODE1);
	wire        hit_baud = (idx == `AST_IDX_BAUD);
	wire        hit_stat = (idx == `AST_IDX_STAT);
	wire        mapped   = hit_buf | hit_ctl | hit_m0 | hit_m1 | hit_baud
		| hit_stat;
	wire        buf_wr   = wr & hit_buf & ~rx_mode;
	wire        stat_wr  = wr & hit_stat;

	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;

	// ============================================================
	// Clock source and receive pin selection, then synchronisers.
	wire src_raw = ck_hi ? i_high_speed_clock
		: (ck_lo ? i_low_speed_clock_x2 : i_low_speed_clock); // R23
	wire rx_raw  = pin_sel ? i_alternate_rx_candidate_pin
		: i_primary_rx_candidate_pin;                         // R1
	wire src_s;
	wire rx_s;

	ast_sync2 u_sync_src (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_async   (src_raw),
		.o_sync    (src_s)
	);

	ast_sync2 u_sync_rx (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_async   (rx_raw),
		.o_sync    (rx_s)
	);

	wire tick   = src_s & ~src_d_reg;
	wire rx_bit = rx_s ^ neg; // R26
	wire rx_on  = comm_enable_reg & rx_mode;
	wire tx_on  = comm_enable_reg & ~rx_mode;
	wire rx_detect = rx_on & (rx_state_reg == RX_HUNT) & ~rx_bit; // R20
	wire tx_start  = tx_on & ~en_d_reg; // R17

	// ============================================================
	// Transfer clock.
	wire tc_fall;
	wire tc_rise;

	ast_baud_gen u_baud (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_tick    (tick),
		.i_run     (comm_enable_reg),
		.i_restart (tx_start | rx_detect),
		.i_count   (baud_divider_count_reg),
		.o_fall    (tc_fall),
		.o_rise    (tc_rise)
	);

	// ============================================================
	// Received word, right-aligned with upper bits forced to zero.
	wire [3:0] pad      = `AST_DATA_MAX - data_len;
	wire [7:0] rx_align = msb_first ? (rx_sh_reg & (8'hff >> pad))
		: (rx_sh_reg >> pad); // R15

	// Transmit frame image, bit 0 goes out first.
	always @*
	begin
		tx_frame = {`AST_FRAME_W{1'b1}};
		tx_frame[0] = 1'b0; // R14
		tx_par = par_odd;
		for (i = 0; i < 8; i = i + 1)
		begin
			if (i < data_len)
			begin
				if (msb_first)
					tx_frame[i+1] = shared_data_buffer_reg[data_len-1-i];
				else
					tx_frame[i+1] = shared_data_buffer_reg[i];
				tx_par = tx_par ^ tx_frame[i+1];
			end
		end
		if (par_en)
			tx_frame[data_len+1] = tx_par; // R4
	end

	// ============================================================
	// Transmitter: one bit per falling transfer-clock edge.
	always @*
	begin
		tx_load = 1'b0;
		tx_done = 1'b0;
		if (tx_on && tc_fall && (tx_left_reg <= `AST_ONE4))
		begin
			tx_load = buffer_full_flag_reg;  // R18
			tx_done = ~buffer_full_flag_reg; // R19
		end
	end

	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tx_sh_reg   <= {`AST_FRAME_W{1'b1}};
			tx_left_reg <= 4'h0;
			tx_line_reg <= 1'b1;
		end
		else if (!tx_on)
		begin
			tx_sh_reg   <= {`AST_FRAME_W{1'b1}};
			tx_left_reg <= 4'h0;
			tx_line_reg <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_line_reg <= tx_frame[0]; // R17
			tx_sh_reg   <= {1'b1, tx_frame[`AST_FRAME_W-1:1]};
			tx_left_reg <= tx_bits;
		end
		else if (tc_fall && (tx_left_reg > `AST_ONE4))
		begin
			tx_line_reg <= tx_sh_reg[0]; // R14
			tx_sh_reg   <= {1'b1, tx_sh_reg[`AST_FRAME_W-1:1]};
			tx_left_reg <= tx_left_reg - `AST_ONE4;
		end
		else if (tx_done)
		begin
			tx_left_reg <= 4'h0;
			tx_line_reg <= 1'b1;
		end
	end

	// ============================================================
	// Receiver: samples on rising edges, loads on the following fall.
	always @*
	begin
		rx_load     = rx_on & (rx_state_reg == RX_LOAD) & tc_fall; // R21
		rx_done     = rx_on & (rx_state_reg == RX_STOP) & tc_rise; // R21
		rx_stop_bad = ~rx_bit;
	end

	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rx_state_reg     <= RX_HUNT;
			rx_cnt_reg       <= 4'h0;
			rx_sh_reg        <= `AST_RST_BYTE;
			rx_start_bad_reg <= 1'b0;
			rx_par_reg       <= 1'b0;
		end
		else if (!rx_on)
			rx_state_reg <= RX_HUNT; // R22
		else
		begin
			case (rx_state_reg)
				RX_HUNT:
				begin
					rx_cnt_reg <= 4'h0;
					if (!rx_bit)
						rx_state_reg <= RX_BITS; // R20
				end
				RX_BITS:
				begin
					if (tc_rise)
					begin
						rx_cnt_reg <= rx_cnt_reg + `AST_ONE4;
						if (rx_cnt_reg == 4'h0)
							rx_start_bad_reg <= rx_bit; // R10
						else if (rx_cnt_reg <= data_len)
						begin
							if (msb_first)
								rx_sh_reg <= {rx_sh_reg[6:0], rx_bit};
							else
								rx_sh_reg <= {rx_bit, rx_sh_reg[7:1]};
						end
						else
							rx_par_reg <= rx_bit;
						if (rx_cnt_reg == data_len + par_cnt)
							rx_state_reg <= RX_LOAD;
					end
				end
				RX_LOAD:
				begin
					if (tc_fall)
						rx_state_reg <= RX_STOP;
				end
				RX_STOP:
				begin
					if (tc_rise)
						rx_state_reg <= RX_HUNT; // R22
				end
				default:
					rx_state_reg <= RX_HUNT;
			endcase
		end
	end

	// ============================================================
	// Registers and flags; a hardware set wins over a status clear.
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			comm_enable_reg         <= 1'b0;
			channel_mode_config_reg <= `AST_RST_BYTE;
			frame_format_config_reg <= `AST_RST_BYTE;
			baud_divider_count_reg  <= `AST_RST_BAUD; // R6
			shared_data_buffer_reg  <= `AST_RST_BYTE;
			framing_error_flag_reg  <= 1'b0;
			overrun_error_flag_reg  <= 1'b0;
			parity_error_flag_reg   <= 1'b0;
			buffer_full_flag_reg    <= 1'b0;
			unread_reg              <= 1'b0;
			en_d_reg                <= 1'b0;
			src_d_reg               <= 1'b1;
		end
		else
		begin
			en_d_reg  <= comm_enable_reg;
			src_d_reg <= src_s;
			if (wr && hit_ctl)
				comm_enable_reg <= i_pwdata[`AST_CTL_EN]; // R25
			else if (tx_done)
				comm_enable_reg <= 1'b0; // R19
			// Mode and baud writes are taken as given; stop first.
			if (wr && hit_m0)
				channel_mode_config_reg <= i_pwdata[7:0];
			if (wr && hit_m1)
				frame_format_config_reg <= i_pwdata[7:0];
			if (wr && hit_baud)
				baud_divider_count_reg <= i_pwdata[15:0];
			if (rx_load)
				shared_data_buffer_reg <= rx_align; // R15
			else if (buf_wr)
				shared_data_buffer_reg <= i_pwdata[7:0];
			unread_reg <= rx_load | (unread_reg & ~(rd & hit_buf));
			if (rx_mode)
				buffer_full_flag_reg <= 1'b0; // R13
			else
				buffer_full_flag_reg <= buf_wr
					| (buffer_full_flag_reg & ~tx_load & ~stat_wr); // R13 R9
			if (!rx_mode)
			begin
				framing_error_flag_reg <= 1'b0; // R10
				overrun_error_flag_reg <= 1'b0; // R11
				parity_error_flag_reg  <= 1'b0; // R12
			end
			else
			begin
				if (rx_done)
				begin
					framing_error_flag_reg <= rx_start_bad_reg | rx_stop_bad; // R10
					parity_error_flag_reg  <= par_en
						& (rx_par_reg ^ (^shared_data_buffer_reg) ^ par_odd); // R12
				end
				else if (stat_wr)
				begin
					framing_error_flag_reg <= 1'b0; // R9
					parity_error_flag_reg  <= 1'b0; // R9
				end
				overrun_error_flag_reg <= (rx_load & unread_reg)
					| (overrun_error_flag_reg & ~stat_wr); // R11 R9
			end
		end
	end

	// ============================================================
	// Read mux; data is captured in the setup cycle.
	always @*
	begin
		rdata_next = 32'h00000000;
		if (hit_buf)
			rdata_next[7:0] = shared_data_buffer_reg;
		else if (hit_ctl)
			rdata_next[`AST_CTL_EN] = comm_enable_reg;
		else if (hit_m0)
			rdata_next[7:0] = channel_mode_config_reg;
		else if (hit_m1)
			rdata_next[7:0] = frame_format_config_reg;
		else if (hit_baud)
			rdata_next[15:0] = baud_divider_count_reg; // R8
		else if (hit_stat)
		begin
			rdata_next[`AST_ST_FER] = framing_error_flag_reg;
			rdata_next[`AST_ST_OER] = overrun_error_flag_reg;
			rdata_next[`AST_ST_PER] = parity_error_flag_reg;
			rdata_next[`AST_ST_FUL] = buffer_full_flag_reg;
		end
	end

	// ============================================================
	// Registered outputs.
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_prdata         <= 32'h00000000;
			o_serial_out_pin <= 1'b1;
			o_uart_irq       <= 1'b0;
		end
		else
		begin
			if (i_psel && !i_penable)
				o_prdata <= rdata_next;
			if (rx_mode)
				o_serial_out_pin <= 1'b1; // R16
			else
				o_serial_out_pin <= tx_line_reg ^ neg; // R26
			o_uart_irq <= tx_load | tx_done | rx_done; // R18 R19 R21
		end
	end

endmodule // ast_uart
`default_nettype wire

// ===== sim/ast_uart_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
// ============================================================
// Port checker for the serial transceiver.
module ast_uart_sva (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [17:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pready,
	input  wire logic        o_serial_out_pin,
	input  wire logic        o_uart_irq
);
	logic        wr;
	logic        rd;
	logic        go;
	logic [15:0] idx;
	logic        rx_reg;
	logic        neg_reg;
	logic [15:0] baud_reg;
	// Decoded completed bus transfers.
	assign idx = i_paddr[17:2];
	assign wr = i_psel & i_penable & o_pready & i_pwrite;
	assign rd = i_psel & i_penable & o_pready & ~i_pwrite;
	assign go = wr && idx == `AST_IDX_CTL && i_pwdata[0] && !rx_reg;
	// Shadow of the mode bits and baud count, so the checks know direction, polarity and count.
	always @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rx_reg <= 1'b0;
			neg_reg <= 1'b0;
			baud_reg <= 16'h00ff;
		end
		else if (wr)
		begin
			if (idx == `AST_IDX_MODE0)
				rx_reg <= i_pwdata[0];
			if (idx == `AST_IDX_MODE1)
				neg_reg <= i_pwdata[5];
			if (idx == `AST_IDX_BAUD)
				baud_reg <= i_pwdata[15:0];
		end
	end
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	// The start level is the inverse of idle in either line logic.
	// The pin register lags the request by one cycle.
	sequence start_irq_s;
		o_uart_irq ##1 (o_serial_out_pin == neg_reg);
	endsequence
	sequence start_hold_s;
		(o_serial_out_pin == neg_reg)[*8];
	endsequence
	// ========================================================
	// Assertions.
	a_start_irq: assert property (go |-> ##[1:3] start_irq_s)
		else $error("no start bit with request after enable");
	a_start_hold: assert property (go |-> ##4 start_hold_s)
		else $error("start bit too short");
	a_bit_stable: assert property (!rx_reg &&
		$changed(o_serial_out_pin) |=> $stable(o_serial_out_pin)[*8])
		else $error("line bit shorter than minimum period");
	a_rx_line_high: assert property (rx_reg && $past(rx_reg)
		|-> o_serial_out_pin) else $error("transmit pin low in receive");
	a_irq_pulse: assert property (o_uart_irq |=> !o_uart_irq)
		else $error("request longer than one cycle");
	a_baud_readback: assert property (rd && idx == `AST_IDX_BAUD
		|-> o_prdata == {16'h0000, baud_reg})
		else $error("baud count reads wrong");
	a_rx_full_zero: assert property (rd && idx == `AST_IDX_STAT
		&& rx_reg |-> !o_prdata[3]) else $error("full flag in receive");
	a_tx_errs_zero: assert property (rd && idx == `AST_IDX_STAT
		&& !rx_reg |-> o_prdata[2:0] == 3'b000)
		else $error("error flag in transmit");
endmodule // ast_uart_sva
bind ast_uart ast_uart_sva u_sva (.i_clk_sys, .i_reset_n, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
	.o_serial_out_pin, .o_uart_irq);
`default_nettype wire

// ===== sim/ast_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Remote serial peer on the receive and transmit lines.
module ast_peer (
	input  wire logic i_clk_sys,
	input  wire logic i_line,
	output logic      o_pri,
	output logic      o_alt
);
	logic cur;
	logic tog;
	logic use_alt;
	initial
	begin
		cur = 1'b1;
		tog = 1'b0;
		use_alt = 1'b0;
	end
	// The idle pin toggles, so picking the wrong pin yields garbage.
	always @(posedge i_clk_sys)
		tog <= ~tog;
	assign o_pri = use_alt ? tog : cur;
	assign o_alt = use_alt ? cur : tog;
	// Sends one positive-logic, LSB-first frame with one stop bit.
	task send(input logic [7:0] d, input int nb, bc, input bit al, bp, bs);
		logic [11:0] b;
		b = 12'hfff;
		b[0] = 1'b0;
		for (int i = 0; i < nb; i++)
			b[i + 1] = d[i];
		b[nb + 1] = ^d ^ bp;
		b[nb + 2] = ~bs;
		use_alt <= al;
		for (int i = 0; i < nb + 3; i++)
		begin
			@(posedge i_clk_sys);
			cur <= b[i];
			repeat (bc - 1) @(posedge i_clk_sys);
		end
		@(posedge i_clk_sys);
		cur <= 1'b1;
	endtask
	// Samples one frame of the device at mid-bit.
	task recv(input int nb, par, stp, bc, input bit neg, msb,
		output logic [7:0] d, output logic pb, output logic ok);
		int n;
		d = 8'h00;
		pb = 1'b0;
		n = 0;
		while (i_line !== neg && n < 4000)
		begin
			@(posedge i_clk_sys);
			n++;
		end
		repeat (bc / 2) @(posedge i_clk_sys);
		ok = (n < 4000) & ~(i_line ^ neg);
		for (int i = 0; i < nb; i++)
		begin
			repeat (bc) @(posedge i_clk_sys);
			d[msb ? nb - 1 - i : i] = i_line ^ neg;
		end
		if (par < 2)
		begin
			repeat (bc) @(posedge i_clk_sys);
			pb = i_line ^ neg;
		end
		for (int i = 0; i < stp; i++)
		begin
			repeat (bc) @(posedge i_clk_sys);
			ok = ok & (i_line ^ neg);
		end
	endtask
endmodule // ast_peer
`default_nettype wire

// ===== sim/test_async_serial_transceiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "ast_defs.vh"
// ============================================================
// Self-checking bench for the serial transceiver.
module test_async_serial_transceiver;
	logic i_clk_sys = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [17:0] i_paddr = 18'h00000;
	logic [31:0] i_pwdata = 32'h00000000;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_serial_out_pin, o_uart_irq;
	logic i_low_speed_clock = 1'b0;
	logic i_low_speed_clock_x2 = 1'b0;
	logic i_high_speed_clock = 1'b0;
	logic i_primary_rx_candidate_pin, i_alternate_rx_candidate_pin;
	logic [5:0] bcnt = 6'd0;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	ast_uart DUT (.i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_low_speed_clock, .i_low_speed_clock_x2, .i_high_speed_clock,
		.i_primary_rx_candidate_pin, .i_alternate_rx_candidate_pin,
		.o_serial_out_pin, .o_uart_irq);
	ast_peer peer (.i_clk_sys, .i_line(o_serial_out_pin),
		.o_pri(i_primary_rx_candidate_pin),
		.o_alt(i_alternate_rx_candidate_pin));
	always #5 i_clk_sys = ~i_clk_sys;
	// Baud sources of 10, 5 and 2.5 MHz; a hang is cut short here.
	always @(posedge i_clk_sys)
	begin
		bcnt <= (bcnt == 6'd39) ? 6'd0 : bcnt + 6'd1;
		i_high_speed_clock <= (bcnt % 10) < 5;
		i_low_speed_clock_x2 <= (bcnt % 20) < 10;
		i_low_speed_clock <= bcnt < 20;
		cyc = cyc + 1;
		if (cyc == 80000)
		begin
			err_count++;
			stop_test();
		end
	end
	// ========================================================
	// Shared tasks.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= {idx, 2'b00};
		i_pwdata <= wd;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk_sys);
			n++;
		end
		while (o_pready !== 1'b1 && n < 20);
		rd = o_prdata;
		err = o_pslverr;
		chk(n < 20, 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task w(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(idx, 1'b1, d, r, e);
	endtask
	task rchk(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(idx, 1'b0, 32'h0, r, e);
		chk({e, r}, {1'b0, exp});
	endtask
	// Waits for one request pulse, sampled mid-cycle where it is settled.
	task wirq;
		int n;
		n = 0;
		while (o_uart_irq !== 1'b1 && n < 6000)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		chk(n < 6000, 1'b1);
		@(negedge i_clk_sys);
	endtask
	task rx_one(input logic [7:0] d, input bit al, bp, bs);
		fork
			peer.send(d, 7, 90, al, bp, bs);
			wirq();
		join
	endtask
	// ========================================================
	// Scenarios.
	task test_reset;
		logic [31:0] r;
		logic e;
		rchk(`AST_IDX_MODE0, 32'h0);
		rchk(`AST_IDX_MODE1, 32'h0);
		rchk(`AST_IDX_BAUD, 32'h00ff);
		rchk(`AST_IDX_STAT, 32'h0);
		rchk(`AST_IDX_CTL, 32'h0);
		apb(16'hf295, 1'b0, 32'h0, r, e);
		chk(e, 1'b1);
		$display("reset test done");
	endtask
	// Two frames, the second loaded from the start-bit request.
	task test_tx(input logic [7:0] m0, m1, input logic [15:0] bd,
		input int nb, par, stp, input bit neg, msb, input int bc,
		input logic [7:0] d0, d1);
		logic [7:0] g, mk;
		logic p, ok;
		mk = 8'hff >> (8 - nb);
		w(`AST_IDX_MODE0, m0);
		w(`AST_IDX_MODE1, m1);
		w(`AST_IDX_BAUD, bd);
		rchk(`AST_IDX_BAUD, bd);
		w(`AST_IDX_BUF, d0);
		rchk(`AST_IDX_STAT, 32'h8);
		w(`AST_IDX_CTL, 32'h1);
		fork
			begin
				peer.recv(nb, par, stp, bc, neg, msb, g, p, ok);
				chk({ok, g}, {1'b1, d0 & mk});
				chk(p, par < 2 ? ^(d0 & mk) ^ par[0] : 1'b0);
				peer.recv(nb, par, stp, bc, neg, msb, g, p, ok);
				chk({ok, g}, {1'b1, d1 & mk});
			end
			begin
				wirq();
				w(`AST_IDX_BUF, d1);
				wirq();
				wirq();
			end
		join
		rchk(`AST_IDX_CTL, 32'h0);
		rchk(`AST_IDX_STAT, 32'h0);
		$display("transmit test done");
	endtask
	task test_rx;
		w(`AST_IDX_MODE0, 8'h05);
		w(`AST_IDX_MODE1, 8'h01);
		w(`AST_IDX_BAUD, 16'h0008);
		w(`AST_IDX_CTL, 32'h1);
		chk(o_serial_out_pin, 1'b1);
		rx_one(8'h55, 0, 0, 0);
		rchk(`AST_IDX_BUF, 32'h55);
		rchk(`AST_IDX_STAT, 32'h0);
		rx_one(8'h2a, 0, 1, 0);
		rchk(`AST_IDX_STAT, 32'h4);
		rchk(`AST_IDX_BUF, 32'h2a);
		rx_one(8'h11, 0, 0, 1);
		w(`AST_IDX_CTL, 32'h0);
		rchk(`AST_IDX_STAT, 32'h1);
		rchk(`AST_IDX_BUF, 32'h11);
		w(`AST_IDX_CTL, 32'h1);
		rx_one(8'h33, 0, 0, 0);
		rx_one(8'h44, 0, 0, 0);
		rchk(`AST_IDX_STAT, 32'h2);
		rchk(`AST_IDX_BUF, 32'h44);
		w(`AST_IDX_STAT, 32'h0);
		rchk(`AST_IDX_STAT, 32'h0);
		w(`AST_IDX_CTL, 32'h0);
		// Idle the alternate pin first, or its toggling fakes a start.
		peer.use_alt <= 1'b1;
		w(`AST_IDX_MODE0, 8'h15);
		w(`AST_IDX_CTL, 32'h1);
		rx_one(8'h6b, 1, 0, 0);
		rchk(`AST_IDX_BUF, 32'h6b);
		chk(o_serial_out_pin, 1'b1);
		$display("receive test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence: reset for five cycles, then each scenario in turn.
	initial
	begin
		repeat (5) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		test_reset();
		test_tx(8'h06, 8'h00, 16'h0003, 8, 0, 1, 0, 0, 90, 8'ha5, 8'h3c);
		test_tx(8'h04, 8'h77, 16'h0008, 5, 1, 2, 1, 1, 90, 8'h13, 8'h0e);
		test_tx(8'h00, 8'h0e, 16'h0008, 6, 2, 1, 0, 0, 360, 8'h2d, 8'h19);
		test_tx(8'h02, 8'h09, 16'h0008, 7, 2, 1, 0, 0, 180, 8'h5a, 8'hda);
		test_rx();
		stop_test();
	end
endmodule // test_async_serial_transceiver
`default_nettype wire
